// >>> ormv_core.sv
// Executor for OR-with-file, move-file, full-range move and pointer load
`timescale 1ns/1ps
// How it works
// [RULE_01] OR accumulator with file, set N Z
// [RULE_02] Destination bit: 0 accumulator, 1 file
// [RULE_03] Access bit 0 access bank, 1 bank pointer
// [RULE_04] File operand reaches whole 256-byte bank
// [RULE_05] Move file to destination, set N Z
// [RULE_06] Pointer load writes 12-bit literal, no flags
// [RULE_07] Pointer load two-word encoding decoded
// [RULE_08] Pointer high four bits first, low byte second
// [RULE_09] Full move uses 12-bit absolute addresses
// [RULE_10] Full move words start 1100, 1111
// [RULE_11] Accumulator allowed either end, no flags
// [RULE_12] Software avoids PC and stack destinations
// [RULE_13] Software avoids interrupt edits while enabled
// [RULE_14] Decode, read, process, write per quarter
// [RULE_15] Full move: read first, write second Q4
// [RULE_16] Stray second word runs as no-op
// [RULE_17] Four quarter phases per instruction cycle
module ormv_core (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] instr,
   input wire logic [7:0] mem_rdata,
   input wire logic [3:0] bank_pointer,
   input wire logic [11:0] acc_addr,
   output ormv_pkg::ormv_mem_t mem_o,
   output logic [7:0] acc_o,
   output ormv_pkg::ormv_flags_t flags_o,
   output logic [1:0] qphase_o,
   output logic instr_fetch_o,
   output logic [11:0] indirect_pointer0_o,
   output logic [11:0] indirect_pointer1_o,
   output logic [11:0] indirect_pointer2_o
);
   // ------------------------------------------------------------
   // Quarter phase sequencer
   // ------------------------------------------------------------
   logic [1:0] qph_r;
   wire q1 = (qph_r == 2'h0);
   wire q2 = (qph_r == 2'h1);
   wire q3 = (qph_r == 2'h2);
   wire q4 = (qph_r == 2'h3);

   // [RULE_17] four quarter phases
   always_ff @(posedge sys_clk) begin
      if (rst) qph_r <= ormv_pkg::QPH_RST;
      else qph_r <= qph_r + 2'h1;
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   ormv_pkg::ormv_state_t st_r, st_nxt;
   logic [15:0] ir_r;
   logic [7:0] acc_r, opnd_r, res_r;
   logic [1:0] psel_r;
   logic [11:0] ptr_r [3];
   ormv_pkg::ormv_flags_t flags_r;
   ormv_pkg::ormv_mem_t mem_r, mem_nxt;

   // [RULE_07] pointer load and full move decode
   wire is_or = (ir_r[15:10] == ormv_pkg::OP_OR_FILE);
   wire is_move_file_byte = (ir_r[15:10] == ormv_pkg::OP_MOVE_FILE);
   // [RULE_10] full move word prefixes
   wire is_full = (ir_r[15:12] == ormv_pkg::OP_FULL_MOVE);
   wire is_ptr = (ir_r[15:6] == ormv_pkg::OP_PTR_LOAD) && (ir_r[5:4] < ormv_pkg::NUM_PTRS);
   wire is_second = (ir_r[15:12] == ormv_pkg::OP_SECOND_WORD);
   wire is_ptr_lo = (ir_r[15:8] == ormv_pkg::OP_PTR_LOAD_LO);
   wire dest_file = ir_r[ormv_pkg::DEST_BIT];

   // [RULE_03] bank selection
   function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bank);
      logic [3:0] hi;
      hi = 4'h0;
      if (w[ormv_pkg::ACCESS_BIT]) hi = bank;
      else if (w[7:0] >= ormv_pkg::ACCESS_SPLIT) hi = ormv_pkg::ACCESS_HI_BANK;
      else hi = 4'h0;
      // [RULE_04] full 8-bit offset
      return {hi, w[7:0]};
   endfunction

   wire [11:0] f_addr = file_addr(ir_r, bank_pointer);
   // Accumulator has a data address too, so it is served internally
   wire [11:0] full_src = ir_r[11:0];
   wire src_is_acc = (full_src == acc_addr);
   wire dst_is_acc = (ir_r[11:0] == acc_addr);
   wire [7:0] opnd_nxt = (is_full && src_is_acc) ? acc_r : mem_rdata;

   // [RULE_01] inclusive OR
   wire [7:0] or_res = acc_r | opnd_r;
   // [RULE_05] move passes operand
   wire [7:0] alu_res = is_or ? or_res : opnd_r;
   // Result from fresh read data: opnd_r only loads on the same Q3 edge
   wire [7:0] res_nxt = is_or ? (acc_r | opnd_nxt) : opnd_nxt;
   wire file_op = (is_or || is_move_file_byte) && (st_r == ormv_pkg::ORMV_EXEC);

   // ------------------------------------------------------------
   // Next state and memory strobes
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      mem_nxt = '0;
      if (q4) begin
         unique case (st_r)
            ormv_pkg::ORMV_EXEC: begin
               // [RULE_08] two-cycle pointer load
               if (is_ptr) st_nxt = ormv_pkg::ORMV_PTR2;
               // [RULE_15] two-cycle full move
               else if (is_full) st_nxt = ormv_pkg::ORMV_MOV2;
            end
            ormv_pkg::ORMV_PTR2: st_nxt = ormv_pkg::ORMV_EXEC;
            ormv_pkg::ORMV_MOV2: st_nxt = ormv_pkg::ORMV_EXEC;
         endcase
      end
      // [RULE_14] read in Q2
      if (q2 && file_op) begin
         mem_nxt.req = 1'b1;
         mem_nxt.addr = f_addr;
      end
      // [RULE_15] source read first cycle
      if (q2 && is_full && !src_is_acc && st_r == ormv_pkg::ORMV_EXEC) begin
         mem_nxt.req = 1'b1;
         mem_nxt.addr = full_src;
      end
      // [RULE_02] write back to file
      if (q4 && file_op && dest_file) begin
         mem_nxt.req = 1'b1;
         mem_nxt.wr = 1'b1;
         mem_nxt.addr = f_addr;
         mem_nxt.wdata = alu_res;
      end
      // [RULE_09] absolute destination write
      if (q4 && st_r == ormv_pkg::ORMV_MOV2 && is_second && !dst_is_acc) begin
         mem_nxt.req = 1'b1;
         mem_nxt.wr = 1'b1;
         mem_nxt.addr = ir_r[11:0];
         mem_nxt.wdata = opnd_r;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= ormv_pkg::ORMV_EXEC;
         ir_r <= 16'h0000;
         mem_r <= '0;
      end else begin
         st_r <= st_nxt;
         mem_r <= mem_nxt;
         // [RULE_14] latch word at decode
         if (q1) ir_r <= instr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         opnd_r <= 8'h00;
         res_r <= 8'h00;
         psel_r <= 2'h0;
      end else begin
         // Read data arrives one edge after the Q2 strobe, so capture in Q3
         if (q3 && (file_op || (is_full && st_r == ormv_pkg::ORMV_EXEC))) opnd_r <= opnd_nxt;
         if (q3 && file_op) res_r <= res_nxt;
         if (q4 && is_ptr && st_r == ormv_pkg::ORMV_EXEC) psel_r <= ir_r[5:4];
      end
   end

   // [RULE_16] stray second word is no-op
   // A lone 1111 word in EXEC matches no first-word decode above, so nothing changes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_r <= ormv_pkg::ACC_RST;
         flags_r <= '0;
      end else if (q4) begin
         if (file_op) begin
            // [RULE_02] accumulator destination
            if (!dest_file) acc_r <= res_r;
            // [RULE_01] negative and zero flags
            flags_r.neg <= res_r[7];
            flags_r.zero <= (res_r == 8'h00);
         end
         // [RULE_11] accumulator as destination
         if (st_r == ormv_pkg::ORMV_MOV2 && is_second && dst_is_acc) acc_r <= opnd_r;
      end
   end

   // [RULE_06] pointer load, flags untouched
   for (genvar i = 0; i < 3; i++) begin : g_ptr
      always_ff @(posedge sys_clk) begin
         if (rst) ptr_r[i] <= ormv_pkg::PTR_RST;
         else if (q4) begin
            // [RULE_08] high four bits in first cycle
            if (st_r == ormv_pkg::ORMV_EXEC && is_ptr && ir_r[5:4] == 2'(i))
               ptr_r[i][11:8] <= ir_r[3:0];
            // [RULE_08] low byte in second cycle
            if (st_r == ormv_pkg::ORMV_PTR2 && is_ptr_lo && psel_r == 2'(i))
               ptr_r[i][7:0] <= ir_r[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic fetch_r;
   always_ff @(posedge sys_clk) begin
      if (rst) fetch_r <= 1'b0;
      else fetch_r <= (qph_r == 2'h3);
   end

   assign mem_o = mem_r;
   assign acc_o = acc_r;
   assign flags_o = flags_r;
   assign qphase_o = qph_r;
   assign instr_fetch_o = fetch_r;
   assign indirect_pointer0_o = ptr_r[0];
   assign indirect_pointer1_o = ptr_r[1];
   assign indirect_pointer2_o = ptr_r[2];
endmodule // ormv_core

// >>> ormv_pkg.sv
// Package: constants and types for the OR / move / pointer-load executor
package ormv_pkg;
   // ------------------------------------------------------------
   // Opcode fields
   // ------------------------------------------------------------
   localparam logic [5:0] OP_OR_FILE = 6'h04;
   localparam logic [5:0] OP_MOVE_FILE = 6'h14;
   localparam logic [3:0] OP_FULL_MOVE = 4'hc;
   localparam logic [3:0] OP_SECOND_WORD = 4'hf;
   localparam logic [9:0] OP_PTR_LOAD = 10'h3b8;
   localparam logic [7:0] OP_PTR_LOAD_LO = 8'hf0;
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   // Access bank split: low half is RAM, high half is special registers
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [1:0] NUM_PTRS = 2'h3;
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic [1:0] QPH_RST = 2'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ORMV_EXEC = 2'b00,
      ORMV_PTR2 = 2'b01,
      ORMV_MOV2 = 2'b10
   } ormv_state_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } ormv_mem_t;

   typedef struct packed {
      logic neg;
      logic zero;
   } ormv_flags_t;
endpackage

// >>> ormv_core_props.sv
// Checker for quarter timing and update moments at the executor ports
`timescale 1ns/1ps
module ormv_core_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire ormv_pkg::ormv_mem_t mem_o,
   input wire logic [7:0] acc_o,
   input wire ormv_pkg::ormv_flags_t flags_o,
   input wire logic [1:0] qphase_o,
   input wire logic instr_fetch_o,
   input wire logic [11:0] indirect_pointer0_o,
   input wire logic [11:0] indirect_pointer1_o,
   input wire logic [11:0] indirect_pointer2_o
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic [35:0] ptrs = {indirect_pointer0_o, indirect_pointer1_o, indirect_pointer2_o};
   a_phase_counts: assert property (1'b1 |=> qphase_o == $past(qphase_o) + 2'h1)
      else $error("quarter phase skipped");
   a_fetch_in_q1: assert property (1'b1 |=> instr_fetch_o == ($past(qphase_o) == 2'h3))
      else $error("fetch outside first quarter");
   a_read_in_q3: assert property (mem_o.req && !mem_o.wr |-> qphase_o == 2'h2)
      else $error("read strobe in wrong quarter");
   a_write_after_q4: assert property (mem_o.req && mem_o.wr |-> qphase_o == 2'h0)
      else $error("write strobe in wrong quarter");
   a_strobe_one_cycle: assert property (mem_o.req |=> !mem_o.req)
      else $error("strobe longer than one cycle");
   a_acc_at_end: assert property ($changed(acc_o) |-> qphase_o == 2'h0)
      else $error("accumulator changed mid cycle");
   a_flags_at_end: assert property ($changed(flags_o) |-> qphase_o == 2'h0)
      else $error("flags changed mid cycle");
   a_ptr_keeps_flags: assert property ($changed(ptrs) |-> qphase_o == 2'h0 && $stable(flags_o))
      else $error("pointer load touched flags");
endmodule // ormv_core_props
bind ormv_core ormv_core_props u_props (.sys_clk(sys_clk), .rst(rst), .mem_o(mem_o),
   .acc_o(acc_o), .flags_o(flags_o), .qphase_o(qphase_o), .instr_fetch_o(instr_fetch_o),
   .indirect_pointer0_o(indirect_pointer0_o), .indirect_pointer1_o(indirect_pointer1_o),
   .indirect_pointer2_o(indirect_pointer2_o));

// >>> or_move_pointer_load_exec_test.sv
// Testbench for the OR / move / pointer-load executor
`timescale 1ns/1ps
module or_move_pointer_load_exec_test;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bank_pointer = 4'h5;
   logic [11:0] acc_addr = 12'hfe8;
   logic [7:0] mem [4096];
   wire logic [7:0] mem_rdata;
   ormv_pkg::ormv_mem_t mem_o;
   ormv_pkg::ormv_flags_t flags_o;
   logic [7:0] acc_o;
   logic [1:0] qphase_o;
   logic instr_fetch_o;
   wire logic [11:0] ptr [3];
   int bad_count = 0;
   int tests_run = 0;
   int writes = 0;
   int snap;
   always #50 sys_clk = ~sys_clk;
   // Data memory answers combinationally within the read quarter
   assign mem_rdata = mem[mem_o.addr];
   always @(posedge sys_clk) begin
      if (mem_o.req === 1'b1 && mem_o.wr === 1'b1) begin
         mem[mem_o.addr] <= mem_o.wdata;
         writes++;
      end
   end
   ormv_core u_dut (.sys_clk(sys_clk), .rst(rst), .instr(instr), .mem_rdata(mem_rdata),
      .bank_pointer(bank_pointer), .acc_addr(acc_addr), .mem_o(mem_o), .acc_o(acc_o),
      .flags_o(flags_o), .qphase_o(qphase_o), .instr_fetch_o(instr_fetch_o),
      .indirect_pointer0_o(ptr[0]), .indirect_pointer1_o(ptr[1]),
      .indirect_pointer2_o(ptr[2]));
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_flags(input ormv_pkg::ormv_flags_t got,
      input ormv_pkg::ormv_flags_t exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One whole instruction cycle per word, presented at Q1
   task automatic step(input logic [15:0] w);
      int n;
      n = 0;
      while (qphase_o !== 2'h0 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 8) begin
         bad_count++;
         print_verdict();
      end
      instr = w;
      repeat (4) @(negedge sys_clk);
   endtask
   // no interrupt setting targets
   // Trailing no-op lets the late write strobe land
   task automatic move(input logic [11:0] src, input logic [11:0] dst);
      step(16'hc000 | 16'(src));
      step(16'hf000 | 16'(dst));
      step(16'h0000);
   endtask
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'h5a;
      mem[12'h5ff] = 8'h91;
      mem[12'h010] = 8'h13;
      mem[12'hf90] = 8'h00;
      mem[12'h011] = 8'h00;
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      step(16'h51ff);
      check_byte(acc_o, 8'h91);
      check_flags(flags_o, 2'b10);
      step(16'h1010);
      check_byte(acc_o, 8'h93);
      check_flags(flags_o, 2'b10);
      step(16'h1290);
      check_byte(acc_o, 8'h93);
      step(16'h5011);
      check_byte(mem[12'hf90], 8'h93);
      check_byte(acc_o, 8'h00);
      check_flags(flags_o, 2'b01);
      for (int f = 0; f < 3; f++) begin
         step(16'hee03 | 16'(f << 4));
         check_word(ptr[f], 12'h300);
         step(16'hf0a0 | 16'(f));
         check_word(ptr[f], 12'h3a0 | 12'(f));
         check_flags(flags_o, 2'b01);
      end
      step(16'hee35);
      step(16'hf055);
      check_word(ptr[2], 12'h3a2);
      move(12'h5ff, 12'h7ff);
      check_byte(mem[12'h7ff], 8'h91);
      move(12'h010, 12'hfe8);
      check_byte(acc_o, 8'h13);
      check_flags(flags_o, 2'b01);
      move(12'hfe8, 12'h100);
      check_byte(mem[12'h100], 8'h13);
      snap = writes;
      step(16'hf123);
      step(16'h0000);
      check_word(12'(writes - snap), 12'h000);
      check_byte(acc_o, 8'h13);
      snap = writes;
      step(16'h5390);
      step(16'h0000);
      check_word(12'(writes - snap), 12'h001);
      check_byte(acc_o, 8'h13);
      check_flags(flags_o, 2'b00);
      print_verdict();
   end
endmodule // or_move_pointer_load_exec_test
